// ==== logic/rtc_pkg.sv ====
// Register map, field positions, reset values and timing of the RTC flag and interrupt block
package rtc_pkg;
    localparam logic [6:0] I2C_DEV_ADDR = 7'h32;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] REG_PAGE = 3'h0;
    localparam logic [3:0] REG_TMR_LO = 4'hb;
    localparam logic [3:0] REG_TMR_HI = 4'hc;
    localparam logic [3:0] REG_EXT = 4'hd;
    localparam logic [3:0] REG_FLAGS = 4'he;
    localparam logic [3:0] REG_CTRL = 4'hf;
    localparam int EXT_TARGET = 6;
    localparam int EXT_REFSEL = 5;
    localparam int EXT_RUN = 4;
    localparam int EXT_CLK = 2;
    localparam int EXT_SRC = 0;
    localparam int FLG_REF = 5;
    localparam int FLG_CNT = 4;
    localparam int FLG_ALM = 3;
    localparam int FLG_SUP = 1;
    localparam int FLG_CMP = 0;
    localparam int CTL_CMP = 6;
    localparam int CTL_REF_EN = 5;
    localparam int CTL_CNT_EN = 4;
    localparam int CTL_ALM_EN = 3;
    localparam int CTL_RST = 0;
    localparam logic [7:0] FLAGS_MASK = 8'h3b;
    localparam logic [7:0] CTRL_MASK = 8'hf9;
    localparam logic [7:0] TMR_HI_MASK = 8'h0f;
    localparam logic [7:0] EXT_RESET = 8'h02;
    localparam logic [7:0] FLAGS_RESET = 8'h03;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam int PRE_32K = 0;
    localparam int PRE_4096 = 3;
    localparam int PRE_1024 = 5;
    localparam int PRE_64 = 9;
    localparam int PRE_2HZ = 14;
    localparam int PRE_1HZ = 15;
    localparam logic [15:0] PRE_LAST = 16'hffff;
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam longint OSC_HZ = 32768;
    localparam longint RTN_SEC_US = 500000;
    localparam longint RTN_MIN_US = 7813;
    localparam longint RTN_FAST_US = 122;
    localparam logic [14:0] RTN_SEC_TICKS = 15'((RTN_SEC_US * OSC_HZ + 999999) / 1000000);
    localparam logic [14:0] RTN_MIN_TICKS = 15'((RTN_MIN_US * OSC_HZ + 999999) / 1000000);
    localparam logic [14:0] RTN_FAST_TICKS = 15'((RTN_FAST_US * OSC_HZ + 999999) / 1000000);
    localparam int HALF_SEC_MS = 500;
    localparam logic [5:0] CMP_LAST_0 = 6'(500 / HALF_SEC_MS - 1);
    localparam logic [5:0] CMP_LAST_1 = 6'(2000 / HALF_SEC_MS - 1);
    localparam logic [5:0] CMP_LAST_2 = 6'(10000 / HALF_SEC_MS - 1);
    localparam logic [5:0] CMP_LAST_3 = 6'(30000 / HALF_SEC_MS - 1);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_RD = 3'b101,
        ST_RD_ACK = 3'b110
    } rtc_i2c_state_t;
endpackage

// ==== logic/rtc_irq_flag_control.sv ====
// RTC flag, interrupt and control logic behind an I2C slave
// Contract
// - Target select 1 ignores weekday; 0 needs weekday match for alarm.
// - Refresh each second released after 500 ms, or each minute after 7.813 ms.
// - Writing timer run 1 loads preset and counts; 0 stops.
// - Clock output select: 00 32768 Hz, 01 1024 Hz, 10 1 Hz, 11 32768 Hz.
// - Countdown tick 4096 Hz, 64 Hz, second or minute; release 122 us or 7.813 ms.
// - Refresh, countdown and alarm flags set on event, held until 0 written.
// - Supply loss flag sets on low supply or oscillator stop, held until cleared.
// - Supply drop seen in about 1 to 10 ms, oscillator stop in 100 ms.
// - Compensation voltage flag sets at compensation instants when supply low.
// - Writing 1 to either supply flag does nothing; only 0 clears.
// - Compensation interval 0.5 s, 2.0 s default, 10 s or 30 s.
// - Refresh pulls irq only when enabled; clearing enable releases it.
// - Countdown pulls irq when enabled, auto release after 122 us or 7.813 ms, enable cancels.
// - Alarm irq held until alarm flag cleared; clearing enable cancels.
// - Reset bit write only sets it; prescaler cleared at next STOP, bit clears.
// - Repeated START never executes the pending prescaler reset.
// - Next second comes 1000 ms minus 30.5 us to 1000 ms after reset; code gives 1000 ms minus 15.3 us to 1000 ms.
// - Unused flag and control bits ignore writes and read zero.
// - Alarm match sets alarm flag and, if enabled, pulls irq low.
// - Timer run 0 stops countdown and releases irq.
module rtc_irq_flag_control
    import rtc_pkg::*;
#(
    parameter int unsigned OSC_STEP = 65536,
    parameter int unsigned OSC_MOD = 100000000
)(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq_n_o,
    output logic irq_n_oe,
    output logic clkout_pin,
    input wire logic supply_low_i,
    input wire logic osc_stop_i,
    input wire logic comp_supply_low_i,
    input wire logic alarm_time_match,
    input wire logic alarm_weekday_match
);
    function automatic logic hit(input logic [7:0] a, input logic [3:0] r);
        return (a[7:5] == REG_PAGE) && (a[3:0] == r);
    endfunction

    logic [4:0] sync1_ff, sync2_ff;
    logic scl_d_ff, sda_d_ff;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_ff <= 5'h03;
            sync2_ff <= 5'h03;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= {comp_supply_low_i, osc_stop_i, supply_low_i, sda_i, scl_i};
            sync2_ff <= sync1_ff;
            scl_d_ff <= sync2_ff[0];
            sda_d_ff <= sync2_ff[1];
        end
    end
    logic scl_s, sda_s, start_det, stop_det, scl_rise, scl_fall;
    assign scl_s = sync2_ff[0];
    assign sda_s = sync2_ff[1];
    assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;

    // I2C slave
    rtc_i2c_state_t st_ff, nxt_st;
    logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, wa_ff, nxt_wa, wd_ff, nxt_wd, rd_val;
    logic [3:0] cnt_ff, nxt_cnt;
    logic first_ff, nxt_first, rw_ff, nxt_rw, ack_ff, nxt_ack, wr_ff, nxt_wr;
    logic sda_oe_ff, nxt_sda_oe;
    always_comb
    begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_ptr = ptr_ff;
        nxt_first = first_ff;
        nxt_rw = rw_ff;
        nxt_ack = ack_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_wr = 1'b0;
        nxt_wa = wa_ff;
        nxt_wd = wd_ff;
        if (start_det)
        begin
            nxt_st = ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
            nxt_first = 1'b1;
        end
        else if (stop_det)
        begin
            nxt_st = ST_IDLE;
            nxt_sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (st_ff)
                ST_ADDR, ST_WR:
                begin
                    nxt_sh = {sh_ff[6:0], sda_s};
                    nxt_cnt = cnt_ff + 4'h1;
                end
                ST_RD: nxt_cnt = cnt_ff + 4'h1;
                ST_RD_ACK: nxt_ack = !sda_s;
                default: nxt_cnt = cnt_ff;
            endcase
        end
        else if (scl_fall)
        begin
            case (st_ff)
                ST_ADDR:
                    if (cnt_ff == BYTE_BITS)
                    begin
                        if (sh_ff[7:1] == I2C_DEV_ADDR)
                        begin
                            nxt_st = ST_ADDR_ACK;
                            nxt_sda_oe = 1'b1;
                            nxt_rw = sh_ff[0];
                        end
                        else
                            nxt_st = ST_IDLE;
                    end
                ST_WR:
                    if (cnt_ff == BYTE_BITS)
                    begin
                        nxt_st = ST_WR_ACK;
                        nxt_sda_oe = 1'b1;
                        nxt_first = 1'b0;
                        if (first_ff)
                            nxt_ptr = sh_ff;
                        else
                        begin
                            nxt_wr = 1'b1;
                            nxt_wa = ptr_ff;
                            nxt_wd = sh_ff;
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                    end
                ST_ADDR_ACK, ST_WR_ACK, ST_RD_ACK:
                begin
                    nxt_cnt = 4'h0;
                    nxt_sda_oe = 1'b0;
                    if (st_ff == ST_RD_ACK && !ack_ff)
                        nxt_st = ST_IDLE;
                    else if (rw_ff)
                    begin
                        nxt_st = ST_RD;
                        nxt_sh = rd_val;
                        nxt_sda_oe = !rd_val[7];
                    end
                    else
                        nxt_st = ST_WR;
                end
                ST_RD:
                    if (cnt_ff == BYTE_BITS)
                    begin
                        nxt_st = ST_RD_ACK;
                        nxt_sda_oe = 1'b0;
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                    else
                    begin
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_sda_oe = !sh_ff[6];
                    end
                default: nxt_st = st_ff;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= ST_IDLE;
            sh_ff <= 8'h00;
            cnt_ff <= 4'h0;
            ptr_ff <= 8'h00;
            first_ff <= 1'b1;
            rw_ff <= 1'b0;
            ack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
            wd_ff <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            ptr_ff <= nxt_ptr;
            first_ff <= nxt_first;
            rw_ff <= nxt_rw;
            ack_ff <= nxt_ack;
            sda_oe_ff <= nxt_sda_oe;
            wr_ff <= nxt_wr;
            wa_ff <= nxt_wa;
            wd_ff <= nxt_wd;
        end
    end

    // Timebase, registers and interrupt sources
    logic [26:0] acc_ff, nxt_acc;
    logic [15:0] presc_ff, nxt_presc, presc_inc;
    logic [5:0] sec_ff, nxt_sec, cmp_ff, nxt_cmp, cmp_last;
    logic [7:0] ext_ff, nxt_ext, flags_ff, nxt_flags, ctrl_ff, nxt_ctrl, tlo_ff, nxt_tlo;
    logic [7:0] thi_ff, nxt_thi, fset, fclr;
    logic [11:0] tcnt_ff, nxt_tcnt;
    logic [14:0] ref_rel_ff, nxt_ref_rel, tmr_rel_ff, nxt_tmr_rel;
    logic ref_act_ff, nxt_ref_act, tmr_act_ff, nxt_tmr_act, alm_act_ff, nxt_alm_act;
    logic irq_oe_ff, clk_ff, nxt_clk;
    logic [27:0] acc_sum;
    logic half_tick, tick_osc, tick_4096, tick_64, tick_2hz, sec_evt, min_evt, rst_exec;
    logic ref_evt, cnt_evt, alm_evt, src_tick, cmp_inst;

    assign rd_val = hit(ptr_ff, REG_TMR_LO) ? tlo_ff :
                    hit(ptr_ff, REG_TMR_HI) ? (thi_ff & TMR_HI_MASK) :
                    hit(ptr_ff, REG_EXT) ? ext_ff :
                    hit(ptr_ff, REG_FLAGS) ? (flags_ff & FLAGS_MASK) :
                    hit(ptr_ff, REG_CTRL) ? (ctrl_ff & CTRL_MASK) : 8'h00;

    always_comb
    begin
        acc_sum = {1'b0, acc_ff} + 28'(OSC_STEP);
        half_tick = acc_sum >= 28'(OSC_MOD);
        nxt_acc = half_tick ? 27'(acc_sum - 28'(OSC_MOD)) : acc_sum[26:0];
        presc_inc = presc_ff + 16'h0001;
        tick_osc = half_tick && presc_inc[PRE_32K] && !presc_ff[PRE_32K];
        tick_4096 = half_tick && presc_inc[PRE_4096] && !presc_ff[PRE_4096];
        tick_64 = half_tick && presc_inc[PRE_64] && !presc_ff[PRE_64];
        tick_2hz = half_tick && presc_inc[PRE_2HZ] && !presc_ff[PRE_2HZ];
        sec_evt = half_tick && (presc_ff == PRE_LAST);
        min_evt = sec_evt && (sec_ff == SEC_LAST);
        rst_exec = stop_det && ctrl_ff[CTL_RST];
        // Only the prescaler restarts so the next second lands one full period on
        nxt_presc = rst_exec ? 16'h0000 : (half_tick ? presc_inc : presc_ff);
        nxt_sec = min_evt ? 6'h00 : (sec_evt ? sec_ff + 6'h01 : sec_ff);
        case (ctrl_ff[CTL_CMP +: 2])
            2'b00: cmp_last = CMP_LAST_0;
            2'b01: cmp_last = CMP_LAST_1;
            2'b10: cmp_last = CMP_LAST_2;
            default: cmp_last = CMP_LAST_3;
        endcase
        cmp_inst = tick_2hz && (cmp_ff >= cmp_last);
        nxt_cmp = cmp_inst ? 6'h00 : (tick_2hz ? cmp_ff + 6'h01 : cmp_ff);
        nxt_ext = (wr_ff && hit(wa_ff, REG_EXT)) ? wd_ff : ext_ff;
        nxt_tlo = (wr_ff && hit(wa_ff, REG_TMR_LO)) ? wd_ff : tlo_ff;
        nxt_thi = (wr_ff && hit(wa_ff, REG_TMR_HI)) ? (wd_ff & TMR_HI_MASK) : thi_ff;
        nxt_ctrl = ctrl_ff;
        if (wr_ff && hit(wa_ff, REG_CTRL))
            nxt_ctrl = (wd_ff & CTRL_MASK) | (ctrl_ff & (8'h01 << CTL_RST));
        if (rst_exec)
            nxt_ctrl[CTL_RST] = 1'b0;
        ref_evt = ext_ff[EXT_REFSEL] ? min_evt : sec_evt;
        case (ext_ff[EXT_SRC +: 2])
            2'b00: src_tick = tick_4096;
            2'b01: src_tick = tick_64;
            2'b10: src_tick = sec_evt;
            default: src_tick = min_evt;
        endcase
        cnt_evt = ext_ff[EXT_RUN] && src_tick && (tcnt_ff <= 12'h001);
        if (nxt_ext[EXT_RUN] && !ext_ff[EXT_RUN])
            nxt_tcnt = {thi_ff[3:0], tlo_ff};
        else if (cnt_evt)
            nxt_tcnt = {thi_ff[3:0], tlo_ff};
        else if (ext_ff[EXT_RUN] && src_tick)
            nxt_tcnt = tcnt_ff - 12'h001;
        else
            nxt_tcnt = tcnt_ff;
        alm_evt = alarm_time_match && (ext_ff[EXT_TARGET] || alarm_weekday_match);
        fset = 8'h00;
        fset[FLG_REF] = ref_evt;
        fset[FLG_CNT] = cnt_evt;
        fset[FLG_ALM] = alm_evt;
        fset[FLG_SUP] = sync2_ff[2] || sync2_ff[3];
        fset[FLG_CMP] = cmp_inst && sync2_ff[4];
        fclr = (wr_ff && hit(wa_ff, REG_FLAGS)) ? ~wd_ff : 8'h00;
        nxt_flags = ((flags_ff & ~fclr) | fset) & FLAGS_MASK;
        nxt_ref_act = ref_act_ff;
        nxt_ref_rel = ref_rel_ff;
        if (!ctrl_ff[CTL_REF_EN])
            nxt_ref_act = 1'b0;
        else if (ref_evt)
        begin
            nxt_ref_act = 1'b1;
            nxt_ref_rel = ext_ff[EXT_REFSEL] ? RTN_MIN_TICKS : RTN_SEC_TICKS;
        end
        else if (ref_act_ff && tick_osc)
        begin
            nxt_ref_act = ref_rel_ff != 15'h0000;
            nxt_ref_rel = ref_rel_ff - 15'h0001;
        end
        nxt_tmr_act = tmr_act_ff;
        nxt_tmr_rel = tmr_rel_ff;
        if (!ctrl_ff[CTL_CNT_EN] || !ext_ff[EXT_RUN])
            nxt_tmr_act = 1'b0;
        else if (cnt_evt)
        begin
            nxt_tmr_act = 1'b1;
            nxt_tmr_rel = (ext_ff[EXT_SRC +: 2] == 2'b00) ? RTN_FAST_TICKS : RTN_MIN_TICKS;
        end
        else if (tmr_act_ff && tick_osc)
        begin
            nxt_tmr_act = tmr_rel_ff != 15'h0000;
            nxt_tmr_rel = tmr_rel_ff - 15'h0001;
        end
        nxt_alm_act = ctrl_ff[CTL_ALM_EN] && nxt_flags[FLG_ALM] && (alm_evt || alm_act_ff);
        case (ext_ff[EXT_CLK +: 2])
            2'b01: nxt_clk = presc_ff[PRE_1024];
            2'b10: nxt_clk = presc_ff[PRE_1HZ];
            default: nxt_clk = presc_ff[PRE_32K];
        endcase
    end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_ff <= 27'h0000000;
            presc_ff <= 16'h0000;
            sec_ff <= 6'h00;
            cmp_ff <= 6'h00;
            ext_ff <= EXT_RESET;
            flags_ff <= FLAGS_RESET;
            ctrl_ff <= CTRL_RESET;
            tlo_ff <= 8'h00;
            thi_ff <= 8'h00;
            tcnt_ff <= 12'h000;
            ref_rel_ff <= 15'h0000;
            tmr_rel_ff <= 15'h0000;
            ref_act_ff <= 1'b0;
            tmr_act_ff <= 1'b0;
            alm_act_ff <= 1'b0;
            irq_oe_ff <= 1'b0;
            clk_ff <= 1'b0;
        end
        else
        begin
            acc_ff <= nxt_acc;
            presc_ff <= nxt_presc;
            sec_ff <= nxt_sec;
            cmp_ff <= nxt_cmp;
            ext_ff <= nxt_ext;
            flags_ff <= nxt_flags;
            ctrl_ff <= nxt_ctrl;
            tlo_ff <= nxt_tlo;
            thi_ff <= nxt_thi;
            tcnt_ff <= nxt_tcnt;
            ref_rel_ff <= nxt_ref_rel;
            tmr_rel_ff <= nxt_tmr_rel;
            ref_act_ff <= nxt_ref_act;
            tmr_act_ff <= nxt_tmr_act;
            alm_act_ff <= nxt_alm_act;
            irq_oe_ff <= ref_act_ff || tmr_act_ff || alm_act_ff;
            clk_ff <= nxt_clk;
        end
    end
    // Open-drain pins only ever pull low
    assign sda_o = 1'b0;
    assign irq_n_o = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign irq_n_oe = irq_oe_ff;
    assign clkout_pin = clk_ff;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    a_supply_set: assert property (sync2_ff[2] |=> flags_ff[FLG_SUP])
        else $error("supply loss flag not set");
    a_one_ignored: assert property (wr_ff && hit(wa_ff, REG_FLAGS) && !flags_ff[FLG_CMP]
        && !cmp_inst |=> !flags_ff[FLG_CMP])
        else $error("writing one set comp flag");
    a_uf_clear: assert property ($fell(flags_ff[FLG_REF]) |-> $past(wr_ff))
        else $error("refresh flag cleared without write");
    a_ref_cancel: assert property (!ctrl_ff[CTL_REF_EN] |=> !ref_act_ff)
        else $error("refresh irq not cancelled");
    a_tmr_stop: assert property (!ext_ff[EXT_RUN] |=> ##1 !irq_oe_ff || ref_act_ff
        || alm_act_ff || $past(ref_act_ff || alm_act_ff))
        else $error("timer stop left irq low");
    a_alarm_hold: assert property (alm_act_ff && ctrl_ff[CTL_ALM_EN] && flags_ff[FLG_ALM]
        && !fclr[FLG_ALM] |=> alm_act_ff)
        else $error("alarm irq released early");
    a_irq_or: assert property (irq_oe_ff ==
        $past(ref_act_ff || tmr_act_ff || alm_act_ff))
        else $error("irq pin not OR of sources");
    a_rst_stop: assert property (rst_exec |=> !ctrl_ff[CTL_RST] && presc_ff == 16'h0000
        ##1 presc_ff <= 16'h0001)
        else $error("prescaler reset not done at stop");
    a_rst_hold: assert property (ctrl_ff[CTL_RST] && !stop_det |=> ctrl_ff[CTL_RST])
        else $error("reset bit lost before stop");
    a_cmp_set: assert property (cmp_inst && sync2_ff[4] |=> flags_ff[FLG_CMP])
        else $error("comp voltage flag not set");
endmodule

// ==== bench/rtc_i2c_host.sv ====
// I2C host model that drives SCL and SDA and reads the wire back
module rtc_i2c_host (
    input wire logic mclk,
    input wire logic sda_w,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    int nacks = 0;
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Quarter of an 80 ns SCL period
    task automatic q();
        repeat (2) @(posedge mclk);
    endtask
    // Data set while SCL low, wire sampled in mid high phase
    task automatic slot(input logic b, output logic r);
        sda <= b;
        q();
        scl <= 1'b1;
        q();
        r = sda_w;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic start();
        sda <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b1;
        q();
    endtask
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            slot(d[i], r);
        slot(1'b1, r);
        if (r)
            nacks++;
    endtask
    // Single byte read, answered with NACK
    task automatic recv(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            slot(1'b1, d[i]);
        slot(1'b1, r);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        start();
        send(8'h64);
        send(p);
        send(d);
        stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        start();
        send(8'h64);
        send(p);
        start();
        send(8'h65);
        recv(d);
        stop();
    endtask
endmodule

// ==== bench/rtc_irq_flag_control_tb.sv ====
// Self-checking bench for the RTC flag, interrupt and control block
module rtc_irq_flag_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic supply_low = 1'b0;
    logic osc_stop = 1'b0;
    logic amatch = 1'b0;
    logic wmatch = 1'b0;
    logic comp_low = 1'b0;
    logic scl;
    logic sda_m;
    logic sda_o;
    logic sda_oe;
    logic irq_n_o;
    logic irq_oe;
    logic clkout;
    // Pull-ups on both open-drain lines
    wire logic sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
    wire logic irq_n = irq_oe ? irq_n_o : 1'b1;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    always #5 mclk = ~mclk;
    rtc_irq_flag_control #(.OSC_STEP(65536), .OSC_MOD(131072)) i_rtc_irq_flag_control (
        .mclk(mclk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_oe), .clkout_pin(clkout),
        .supply_low_i(supply_low), .osc_stop_i(osc_stop), .comp_supply_low_i(comp_low),
        .alarm_time_match(amatch), .alarm_weekday_match(wmatch));
    rtc_i2c_host i_rtc_i2c_host (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda(sda_m));
    task automatic end_sim();
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 70000)
        begin
            errors++;
            end_sim();
        end
    end
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] e, input string n);
        logic [7:0] v;
        i_rtc_i2c_host.rd(p, v);
        `CHK(n, e, v)
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        i_rtc_i2c_host.wr(p, v);
    endtask
    task automatic pulse_match(input logic wk);
        wmatch <= wk;
        amatch <= 1'b1;
        @(posedge mclk);
        amatch <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_reset_values();
        rd_chk(8'(REG_EXT), EXT_RESET, "ext");
        rd_chk(8'(REG_FLAGS), FLAGS_RESET, "flags");
        rd_chk(8'(REG_CTRL), CTRL_RESET, "ctrl");
        wr(8'h05, 8'hff);
        rd_chk(8'h05, 8'h00, "unmapped");
    endtask
    task automatic t_flags();
        wr(8'(REG_FLAGS), 8'hff);
        rd_chk(8'(REG_FLAGS), 8'h03, "flags w1");
        // Supply loss seen, so registers are set up again before use
        wr(8'(REG_FLAGS), 8'h00);
        wr(8'(REG_EXT), 8'h00);
        rd_chk(8'(REG_FLAGS), 8'h00, "flags w0");
        for (int k = 0; k < 2; k++)
        begin
            supply_low <= (k == 0);
            osc_stop <= (k == 1);
            repeat (20) @(posedge mclk);
            supply_low <= 1'b0;
            osc_stop <= 1'b0;
            rd_chk(8'(REG_FLAGS), 8'h02, "loss");
            wr(8'(REG_FLAGS), 8'h00);
        end
    endtask
    task automatic t_ctrl();
        logic [7:0] v;
        wr(8'(REG_CTRL), 8'hff);
        rd_chk(8'(REG_CTRL), 8'hf8, "ctrl mask");
        i_rtc_i2c_host.start();
        i_rtc_i2c_host.send(8'h64);
        i_rtc_i2c_host.send(8'h0f);
        i_rtc_i2c_host.send(8'h41);
        i_rtc_i2c_host.start();
        i_rtc_i2c_host.send(8'h64);
        i_rtc_i2c_host.send(8'h0f);
        i_rtc_i2c_host.start();
        i_rtc_i2c_host.send(8'h65);
        i_rtc_i2c_host.recv(v);
        i_rtc_i2c_host.stop();
        `CHK("rst pend", 8'h41, v)
        rd_chk(8'(REG_CTRL), 8'h40, "rst done");
    endtask
    task automatic t_clkout();
        int exp_n[4] = '{320, 10, 0, 320};
        int cnt;
        logic prev;
        for (int s = 0; s < 4; s++)
        begin
            wr(8'(REG_EXT), {4'h0, 2'(s), 2'b00});
            cnt = 0;
            prev = clkout;
            repeat (1280)
            begin
                @(negedge mclk);
                if (clkout && !prev)
                    cnt++;
                prev = clkout;
            end
            `CHK("clkout", 1'b1, (cnt >= exp_n[s] - 1 && cnt <= exp_n[s] + 1))
        end
    endtask
    task automatic t_alarm();
        wr(8'(REG_CTRL), 8'h48);
        wr(8'(REG_EXT), 8'h40);
        pulse_match(1'b0);
        `CHK("alm irq", 1'b0, irq_n)
        rd_chk(8'(REG_FLAGS), 8'h08, "alm flag");
        wr(8'(REG_CTRL), 8'h40);
        `CHK("alm cancel", 1'b0, irq_oe)
        wr(8'(REG_CTRL), 8'h48);
        pulse_match(1'b0);
        `CHK("alm hold", 1'b1, irq_oe)
        wr(8'(REG_FLAGS), 8'h00);
        `CHK("alm clr", 1'b0, irq_oe)
        wr(8'(REG_EXT), 8'h00);
        pulse_match(1'b0);
        rd_chk(8'(REG_FLAGS), 8'h00, "wk miss");
        pulse_match(1'b1);
        rd_chk(8'(REG_FLAGS), 8'h08, "wk hit");
        wr(8'(REG_FLAGS), 8'h00);
    endtask
    task automatic t_countdown();
        int w;
        wr(8'(REG_TMR_LO), 8'h02);
        wr(8'(REG_TMR_HI), 8'h00);
        wr(8'(REG_CTRL), 8'h50);
        wr(8'(REG_EXT), 8'h10);
        w = 0;
        while (irq_oe !== 1'b1 && w < 400)
        begin
            @(negedge mclk);
            w++;
        end
        `CHK("cnt irq", 1'b1, irq_oe)
        w = 0;
        while (irq_oe === 1'b1 && w < 100)
        begin
            @(negedge mclk);
            w++;
        end
        `CHK("cnt rel", 1'b1, (w >= 12 && w <= 40))
        rd_chk(8'(REG_FLAGS), 8'h10, "cnt flag");
        wr(8'(REG_FLAGS), 8'h00);
        repeat (200) @(posedge mclk);
        rd_chk(8'(REG_FLAGS), 8'h10, "reload");
        wr(8'(REG_EXT), 8'h00);
        `CHK("stop rel", 1'b0, irq_oe)
        wr(8'(REG_FLAGS), 8'h00);
        w = 0;
        repeat (300)
        begin
            @(negedge mclk);
            w += int'(irq_oe);
        end
        `CHK("stopped", 0, w)
        rd_chk(8'(REG_FLAGS), 8'h00, "no event");
    endtask
    task automatic t_comp();
        comp_low <= 1'b1;
        // Prescaler restart puts the first half-second instant a known time away
        wr(8'(REG_CTRL), 8'h01);
        rd_chk(8'(REG_FLAGS), 8'h00, "cmp wait");
        repeat (33000) @(posedge mclk);
        rd_chk(8'(REG_FLAGS), 8'h01, "cmp set");
        wr(8'(REG_FLAGS), 8'hff);
        rd_chk(8'(REG_FLAGS), 8'h01, "cmp w1");
        comp_low <= 1'b0;
        wr(8'(REG_FLAGS), 8'h00);
        rd_chk(8'(REG_FLAGS), 8'h00, "cmp w0");
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
        t_reset_values();
        t_flags();
        t_ctrl();
        t_clkout();
        t_alarm();
        t_countdown();
        t_comp();
        `CHK("acks", 0, i_rtc_i2c_host.nacks)
        end_sim();
    end
endmodule
